// ==== src/rom_with_io_bus_interface.sv ====
/*
 * Bus-side logic of a 2048-byte ROM with two 8-bit general-purpose ports.
 * Assumes host strobes arrive asynchronously and are sampled on clk.
 */
`default_nettype none
module rom_with_io_bus_interface #(
	parameter logic [2047:0][7:0] ROM_INIT = '0
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] muxed_addr_data_bus_in,
	output logic      [7:0] muxed_addr_data_bus_out,
	output logic      [7:0] muxed_addr_data_bus_oe,
	input  wire logic       addr_latch_enable,
	input  wire logic       io_mem_qual,
	input  wire logic [2:0] upper_rom_addr,
	input  wire logic       chip_select_low_active_n,
	input  wire logic       chip_select_high_active,
	input  wire logic       mem_read_strobe_n,
	input  wire logic       port_read_strobe_n,
	input  wire logic       port_write_strobe_n,
	input  wire logic       device_clock,
	input  wire logic       port_reset,
	output logic            ready_out,
	output logic            ready_oe,
	input  wire logic [7:0] first_port_pins_in,
	output logic      [7:0] first_port_pins_out,
	output logic      [7:0] first_port_pins_oe,
	input  wire logic [7:0] second_port_pins_in,
	output logic      [7:0] second_port_pins_out,
	output logic      [7:0] second_port_pins_oe
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int unsigned NS = 36;
	// Idle levels: selects off, strobes high, address strobe, device clock and reset low.
	localparam logic [NS-1:0] IDLE = 36'h00000005C;
	logic [NS-1:0] raw;
	logic [NS-1:0] s2;
	logic [NS-1:0] s3;
	logic [NS-1:0] st;

	assign raw = {second_port_pins_in, first_port_pins_in, muxed_addr_data_bus_in,
		addr_latch_enable, io_mem_qual, upper_rom_addr, chip_select_low_active_n,
		chip_select_high_active, mem_read_strobe_n, port_read_strobe_n,
		port_write_strobe_n, device_clock, port_reset};

	pin_sync #(.W(NS), .RST(IDLE)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    (raw),
		.init (IDLE),
		.q2   (s2),
		.q3   (s3)
	);

	// A change is accepted only once stages two and three agree.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= IDLE;
		end else begin
			st <= (s2 & s3) | (st & (s2 | s3));
		end
	end

	wire [7:0] pb_in    = st[35:28];
	wire [7:0] pa_in    = st[27:20];
	wire [7:0] bus_in   = st[19:12];
	wire       ale      = st[11];
	wire       ioq      = st[10];
	wire [2:0] upper    = st[9:7];
	wire       ce_n     = st[6];
	wire       ce       = st[5];
	wire       rd_n     = st[4];
	wire       ior_n    = st[3];
	wire       iow_n    = st[2];
	wire       dclk_s   = st[1];
	wire       preset_s = st[0];

	// ---------------------------------------------------------------
	// Address latch
	// ---------------------------------------------------------------
	logic ale_d;
	rom_io_pkg::latch_t lat;
	wire ale_fall = ale_d & ~ale;
	wire sel_now  = ~ce_n & ce;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ale_d <= 1'b0;
			lat   <= '0;
		end else begin
			ale_d <= ale;
			if (ale_fall) begin
				lat <= '{low_addr: bus_in, io_qual: ioq, upper: upper, sel_ok: sel_now};
			end
		end
	end

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire [1:0] port_ofs = lat.low_addr[1:0];
	wire io_rd    = ~ior_n | (lat.io_qual & ~rd_n);
	wire any_rd   = ~rd_n | ~ior_n;
	wire rd_act   = lat.sel_ok & any_rd;
	wire port_rd  = lat.sel_ok & io_rd;
	wire wr_act   = lat.sel_ok & ~iow_n;
	wire [10:0] rom_addr = {lat.upper, lat.low_addr};

	logic [7:0] out_a;
	logic [7:0] out_b;
	logic [7:0] dir_a;
	logic [7:0] dir_b;

	wire [7:0] rd_a = (dir_a & out_a) | (~dir_a & pa_in);
	wire [7:0] rd_b = (dir_b & out_b) | (~dir_b & pb_in);
	wire [7:0] port_val = (port_ofs == rom_io_pkg::OFS_DATA_A) ? rd_a :
		(port_ofs == rom_io_pkg::OFS_DATA_B) ? rd_b :
		(port_ofs == rom_io_pkg::OFS_DIR_A) ? dir_a : dir_b;
	wire [7:0] rd_val = port_rd ? port_val : ROM_INIT[rom_addr];

	// ---------------------------------------------------------------
	// Port registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_a <= rom_io_pkg::OUT_RESET;
			out_b <= rom_io_pkg::OUT_RESET;
			dir_a <= rom_io_pkg::DIR_RESET;
			dir_b <= rom_io_pkg::DIR_RESET;
		end else if (preset_s) begin
			dir_a <= rom_io_pkg::DIR_RESET;
			dir_b <= rom_io_pkg::DIR_RESET;
		end else if (wr_act) begin
			case (port_ofs)
				rom_io_pkg::OFS_DATA_A: out_a <= bus_in;
				rom_io_pkg::OFS_DATA_B: out_b <= bus_in;
				rom_io_pkg::OFS_DIR_A: dir_a <= bus_in;
				rom_io_pkg::OFS_DIR_B: dir_b <= bus_in;
				default: out_a <= out_a;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Ready
	// ---------------------------------------------------------------
	logic dclk_d;
	logic ready_hold;
	wire dclk_rise = dclk_s & ~dclk_d;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dclk_d     <= 1'b0;
			ready_hold <= 1'b0;
		end else begin
			dclk_d <= dclk_s;
			if (ale & sel_now) begin
				ready_hold <= 1'b1;
			end else if (dclk_rise) begin
				ready_hold <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			muxed_addr_data_bus_out <= 8'h00;
			muxed_addr_data_bus_oe  <= 8'h00;
			ready_out               <= 1'b0;
			ready_oe                <= 1'b0;
			first_port_pins_out     <= 8'h00;
			first_port_pins_oe      <= 8'h00;
			second_port_pins_out    <= 8'h00;
			second_port_pins_oe     <= 8'h00;
		end else begin
			muxed_addr_data_bus_out <= rd_val;
			muxed_addr_data_bus_oe  <= {8{rd_act}};
			ready_out               <= 1'b0;
			ready_oe                <= ready_hold;
			first_port_pins_out     <= out_a;
			first_port_pins_oe      <= dir_a;
			second_port_pins_out    <= out_b;
			second_port_pins_oe     <= dir_b;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_release;
		@(posedge clk) disable iff (!rstn) (rd_n & ior_n) |-> ##1 (muxed_addr_data_bus_oe == 8'h00);
	endproperty
	a_release: assert property (p_release) else $error("Bus not released.");

	property p_unsel;
		@(posedge clk) disable iff (!rstn) !lat.sel_ok |-> ##1 (muxed_addr_data_bus_oe == 8'h00);
	endproperty
	a_unsel: assert property (p_unsel) else $error("Unselected device drives bus.");

	property p_drive;
		@(posedge clk) disable iff (!rstn) rd_act |-> ##1 (muxed_addr_data_bus_oe == 8'hFF);
	endproperty
	a_drive: assert property (p_drive) else $error("Read did not drive bus.");

	property p_wr_a;
		@(posedge clk) disable iff (!rstn)
			(wr_act & !preset_s & port_ofs == rom_io_pkg::OFS_DATA_A) |=> (out_a == $past(bus_in));
	endproperty
	a_wr_a: assert property (p_wr_a) else $error("First port not written.");

	property p_wr_b;
		@(posedge clk) disable iff (!rstn)
			(wr_act & !preset_s & port_ofs == rom_io_pkg::OFS_DATA_B) |=> (out_b == $past(bus_in));
	endproperty
	a_wr_b: assert property (p_wr_b) else $error("Second port not written.");

	property p_reset_in;
		@(posedge clk) disable iff (!rstn) preset_s |=> ##1 (first_port_pins_oe == 8'h00 && second_port_pins_oe == 8'h00);
	endproperty
	a_reset_in: assert property (p_reset_in) else $error("Ports not inputs under reset.");

	property p_ready;
		@(posedge clk) disable iff (!rstn) (ale & sel_now) |=> ##1 ready_oe && !ready_out;
	endproperty
	a_ready: assert property (p_ready) else $error("Ready not driven low.");

	property p_ready_rel;
		@(posedge clk) disable iff (!rstn) (dclk_rise & !(ale & sel_now)) |=> ##1 !ready_oe;
	endproperty
	a_ready_rel: assert property (p_ready_rel) else $error("Ready not released.");
endmodule
`default_nettype wire

// ==== src/rom_io_pkg.sv ====
/*
 * Constants and carrier types for the ROM with two general-purpose ports.
 * Assumes a single 250 MHz system clock; all pins are sampled by the top.
 */
// Overview of operation
// - Host puts low address byte on shared bus while address strobe high.
// - Address strobe falling edge latches bus byte, qualifier, upper address, selects.
// - Respond only if latched low-select low and high-select high; else float.
// - Upper ROM address lines never affect port selection or port operations.
// - Memory read with qualifier high reads a port; qualifier low reads ROM.
// - Selected memory read low enables bus drivers with ROM byte or port.
// - Both memory read and port read strobes high release the bus drivers.
// - Selected port write stores bus byte into the register chosen by address bits one and zero.
// - Port read: selected, port read low or qualifier-and-read; address bits one and zero pick the register.
// - Port read strobe equals qualifier high with memory read strobe low.
// - First port is written when latched address bit zero was zero.
// - Second port identical to first, selected when address bit zero was one.
// - Each of sixteen port pins is input or output by its direction bit.
// - Two general-purpose ports of eight pins each.
// - Store holds 2048 bytes addressed by upper lines and latched low byte.
// - Ready driven low while selects active with address strobe high, until clock rise.
// - Device clock rising edge returns ready to high impedance.
// - Reset input high switches every port pin to input.
`default_nettype none
package rom_io_pkg;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned UPPER_W    = 3;
	localparam int unsigned ROM_AW     = 11;
	localparam int unsigned ROM_DEPTH  = 2048;
	localparam int unsigned SYNC_DEPTH = 3;
	// Port-space offsets in the latched low byte.
	localparam logic [1:0] OFS_DATA_A = 2'h0;
	localparam logic [1:0] OFS_DATA_B = 2'h1;
	localparam logic [1:0] OFS_DIR_A  = 2'h2;
	localparam logic [1:0] OFS_DIR_B  = 2'h3;
	localparam logic [7:0] DIR_RESET  = 8'h00;
	localparam logic [7:0] OUT_RESET  = 8'h00;

	typedef struct packed {
		logic [7:0] low_addr;
		logic       io_qual;
		logic [2:0] upper;
		logic       sel_ok;
	} latch_t;

	typedef struct packed {
		logic [7:0] data_out;
		logic [7:0] data_oe;
	} bus_drive_t;
endpackage
`default_nettype wire

// ==== src/pin_sync.sv ====
/*
 * Three-stage synchroniser for a bundle of asynchronous pins.
 * Assumes the reader looks only at the returned stage pair.
 */
`default_nettype none
module pin_sync #(
	parameter int unsigned   W   = 1,
	parameter logic [W-1:0]  RST = '1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] init,
	output logic      [W-1:0] q2,
	output logic      [W-1:0] q3
);
	logic [W-1:0] s1;

	// Reset to the pins' idle levels, so that no false edge follows release.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1 <= RST;
			q2 <= RST;
			q3 <= RST;
		end else begin
			s1 <= d;
			q2 <= s1;
			q3 <= q2;
		end
	end

	logic unused_init;
	assign unused_init = ^init;
endmodule
`default_nettype wire

// ==== verification/host_bus_model.sv ====
/*
 * Host side of the multiplexed address/data bus, driven by tasks.
 * Assumes the caller samples the device between the task calls.
 */
`default_nettype none
module host_bus_model (
	input  wire logic       clk,
	output logic      [7:0] host_bus,
	output logic            ale,
	output logic            io_qual,
	output logic      [2:0] upper,
	output logic            cs_n,
	output logic            cs,
	output logic            rd_n,
	output logic            ior_n,
	output logic            iow_n,
	output logic            dev_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{host_bus, ale, io_qual, upper, cs_n, cs, dev_clk} = 16'h0200;
		{rd_n, ior_n, iow_n} = 3'h7;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic addr_phase(input logic [10:0] a, input logic q, input logic sel);
		step(1);
		ale = 1'h1;
		host_bus = a[7:0];
		upper = a[10:8];
		io_qual = q;
		cs_n = ~sel;
		cs = sel;
		step(10);
	endtask
	// Inputs flip after the latch edge so that only latched values can count.
	task automatic latch();
		ale = 1'h0;
		step(2);
		host_bus = ~host_bus;
		upper = ~upper;
		io_qual = ~io_qual;
		cs_n = ~cs_n;
		cs = ~cs;
		dev_clk = 1'h1;
		step(8);
		dev_clk = 1'h0;
		step(8);
	endtask
	task automatic strobe(input logic [1:0] kind, input logic [7:0] d);
		if (kind == 2'h2)
			host_bus = d;
		rd_n = (kind != 2'h0);
		ior_n = (kind != 2'h1);
		iow_n = (kind != 2'h2);
		step(10);
	endtask
	// A released bus has no pull, so it shows the inverse of its last value.
	task automatic release_bus();
		{rd_n, ior_n, iow_n} = 3'h7;
		host_bus = ~host_bus;
		step(12);
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the ROM with two general-purpose ports.
 * Assumes the design's pin synchronisers add under eight clocks of delay.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk = 1'h0;
	logic            rstn = 1'h0;
	logic            port_reset = 1'h0;
	logic      [7:0] ext_a = 8'h96;
	logic      [7:0] ext_b = 8'h3C;
	int              bad_count = 0;
	int              comparisons = 0;
	wire logic [7:0] h_bus, bus_out, bus_oe, bus_in, a_out, a_oe, a_in, b_out, b_oe, b_in;
	wire logic [2:0] upper;
	wire logic       ale, qual, cs_n, cs, rd_n, ior_n, iow_n, dclk, rdy, rdy_oe;
	assign bus_in = (bus_oe & bus_out) | (~bus_oe & h_bus);
	assign a_in = (a_oe & a_out) | (~a_oe & ext_a);
	assign b_in = (b_oe & b_out) | (~b_oe & ext_b);
	always #2 clk = ~clk;
	function automatic logic [7:0] rom_byte(input logic [10:0] a);
		return a[7:0] ^ {a[10:8], 5'h15};
	endfunction
	function automatic logic [2047:0][7:0] rom_image();
		for (int i = 0; i < 2048; i++)
			rom_image[i] = rom_byte(i[10:0]);
	endfunction
	host_bus_model m (.clk(clk), .host_bus(h_bus), .ale(ale), .io_qual(qual), .upper(upper),
		.cs_n(cs_n), .cs(cs), .rd_n(rd_n), .ior_n(ior_n), .iow_n(iow_n), .dev_clk(dclk));
	rom_with_io_bus_interface #(.ROM_INIT(rom_image())) dut (.clk(clk), .rstn(rstn),
		.muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(bus_out),
		.muxed_addr_data_bus_oe(bus_oe), .addr_latch_enable(ale), .io_mem_qual(qual),
		.upper_rom_addr(upper), .chip_select_low_active_n(cs_n), .chip_select_high_active(cs),
		.mem_read_strobe_n(rd_n), .port_read_strobe_n(ior_n), .port_write_strobe_n(iow_n),
		.device_clock(dclk), .port_reset(port_reset), .ready_out(rdy), .ready_oe(rdy_oe),
		.first_port_pins_in(a_in), .first_port_pins_out(a_out), .first_port_pins_oe(a_oe),
		.second_port_pins_in(b_in), .second_port_pins_out(b_out), .second_port_pins_oe(b_oe));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic access(input logic [10:0] a, input logic q, input logic sel,
		input logic [1:0] kind, input logic [7:0] d);
		m.addr_phase(a, q, sel);
		check({7'h00, rdy_oe}, {7'h00, sel});
		check({7'h00, rdy}, 8'h00);
		m.latch();
		check({7'h00, rdy_oe}, 8'h00);
		m.strobe(kind, d);
		if (kind != 2'h2) begin
			check(bus_oe, sel ? 8'hFF : 8'h00);
			if (sel)
				check(bus_out, d);
		end
		m.release_bus();
		check(bus_oe, 8'h00);
	endtask
	task automatic t_ports_read();
		access(11'h501, 1'h1, 1'h1, 2'h1, 8'h3C);
		access(11'h201, 1'h1, 1'h1, 2'h0, 8'h3C);
		access(11'h000, 1'h1, 1'h1, 2'h1, 8'h96);
		$display("test ports_read done");
	endtask
	task automatic t_rom();
		access(11'h5A7, 1'h0, 1'h1, 2'h0, rom_byte(11'h5A7));
		access(11'h7FF, 1'h0, 1'h1, 2'h0, rom_byte(11'h7FF));
		access(11'h001, 1'h0, 1'h1, 2'h0, rom_byte(11'h001));
		$display("test rom done");
	endtask
	task automatic t_writes();
		access(11'h702, 1'h1, 1'h1, 2'h2, 8'hFF);
		access(11'h300, 1'h0, 1'h1, 2'h2, 8'h5A);
		check(a_oe, 8'hFF);
		check(a_out, 8'h5A);
		access(11'h003, 1'h1, 1'h1, 2'h2, 8'h0F);
		access(11'h601, 1'h1, 1'h1, 2'h2, 8'hC3);
		check(b_oe, 8'h0F);
		check(b_out, 8'hC3);
		access(11'h001, 1'h1, 1'h1, 2'h1, 8'h33);
		$display("test writes done");
	endtask
	task automatic t_unselected();
		access(11'h000, 1'h1, 1'h0, 2'h2, 8'h11);
		access(11'h5A7, 1'h0, 1'h0, 2'h0, 8'h00);
		check(a_out, 8'h5A);
		$display("test unselected done");
	endtask
	task automatic t_port_reset();
		m.step(1);
		port_reset = 1'h1;
		m.step(12);
		check(a_oe, 8'h00);
		check(b_oe, 8'h00);
		port_reset = 1'h0;
		$display("test port_reset done");
	endtask
	task automatic complete_run();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		m.step(12);
		rstn = 1'h1;
		m.step(8);
		check(a_oe | b_oe | bus_oe, 8'h00);
		t_ports_read();
		t_rom();
		t_writes();
		t_unselected();
		t_port_reset();
		complete_run();
	end
	// Thirteen accesses of about fifty clocks each; the limit leaves wide slack.
	initial begin
		#40000;
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
